// file: afr_pkg.sv
// Shared constants of the offset calibration and measurement readback block.
// Assumes 32-bit register frames already assembled by the serial front end.
package afr_pkg;

    // ----------------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------------
    localparam int          FRAME_W       = 32;
    localparam int          RW_BIT        = 31;
    localparam int          CODE_HI       = 30;
    localparam int          CODE_LO       = 27;
    localparam int          CHAN_HI       = 25;
    localparam int          CHAN_LO       = 24;
    localparam logic [3:0]  CODE_OFFSET   = 4'h7;
    localparam logic [3:0]  CODE_READBACK = 4'h8;
    localparam logic [1:0]  CHAN_ONE      = 2'h1;
    localparam logic [1:0]  CHAN_TWO      = 2'h2;

    // ----------------------------------------------------------------------
    // Offset calibration register fields
    // ----------------------------------------------------------------------
    localparam int          TRIGGER_BIT   = 23;
    localparam int          OFFSET_W      = 13;
    localparam logic [12:0] OFFSET_RST    = 13'h0000;

    // ----------------------------------------------------------------------
    // Measurement readback register fields
    // ----------------------------------------------------------------------
    localparam int          CAL_LO        = 8;
    localparam int          CAL_W         = 16;
    localparam int          ACC_LO        = 12;
    localparam int          ACC_W         = 12;
    localparam int          PERIOD_LO     = 0;
    localparam int          PERIOD_W      = 12;
    localparam int          PEAK_LO       = 16;
    localparam int          TROUGH_LO     = 8;
    localparam int          CYC_LO        = 0;
    localparam int          CUR_W         = 8;
    localparam logic [7:0]  PEAK_RST      = 8'h00;
    localparam logic [7:0]  TROUGH_RST    = 8'hFF;
    localparam logic [7:0]  CYC_RST       = 8'h00;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int          PERIOD_LSB_CLKS = 16;
    localparam logic [3:0]  TICK_LAST       = 4'(PERIOD_LSB_CLKS - 1);

endpackage

// file: afr_chan_meas.sv
// One channel's measurement keeper: offset result, switching period,
// accumulated current, peak, trough and cycles per dither cycle.
// Assumes measurement strobes from the analogue path, synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module afr_chan_meas
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        chanOn,
    input  wire logic        ditherOn,
    input  wire logic        sampleValid,
    input  wire logic [7:0]  sampleCur,
    input  wire logic        cycleEnd,
    input  wire logic [11:0] accIn,
    input  wire logic        ditherEnd,
    input  wire logic        azDone,
    input  wire logic [12:0] azValue,
    input  wire logic        clrAcc,
    input  wire logic        clrPeak,
    output logic      [12:0] offsetReg,
    output logic      [11:0] accReg,
    output logic      [11:0] periodReg,
    output logic      [7:0]  peakRep,
    output logic      [7:0]  troughRep,
    output logic      [7:0]  cycRep
);

    logic [3:0]  tickCnt_reg;
    logic        tick;
    logic [11:0] periodRun_reg;
    logic [7:0]  peakRun_reg;
    logic [7:0]  troughRun_reg;
    logic [7:0]  cycRun_reg;
    logic [7:0]  peakHold_reg;
    logic [7:0]  troughHold_reg;
    logic [7:0]  cycHold_reg;

    // --------------------------------------------------------------------
    // Offset result
    // --------------------------------------------------------------------
    // Latches the offset when the calibration sequence reports completion.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            offsetReg <= afr_pkg::OFFSET_RST;
        else if (azDone)
            offsetReg <= azValue;
    end

    // --------------------------------------------------------------------
    // Period measurement in units of sixteen clocks
    // --------------------------------------------------------------------
    // Divider that gives one enable pulse every sixteen clocks.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !chanOn || cycleEnd)
            tickCnt_reg <= 4'h0;
        else
            tickCnt_reg <= tickCnt_reg + 4'h1;
    end

    assign tick = (tickCnt_reg == afr_pkg::TICK_LAST);

    // Counts ticks within a switching cycle, saturating at full scale.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !chanOn || cycleEnd)
            periodRun_reg <= 12'h000;
        else if (tick && periodRun_reg != 12'hFFF)
            periodRun_reg <= periodRun_reg + 12'h001;
    end

    // Last cycle's period and accumulated current; new data beats a read clear.
    // A tick that falls due on the capture edge completes the last sixteen-clock unit.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !chanOn)
        begin
            periodReg <= 12'h000;
            accReg    <= 12'h000;
        end
        else if (cycleEnd)
        begin
            periodReg <= periodRun_reg + {11'h000, tick && periodRun_reg != 12'hFFF};
            accReg    <= accIn;
        end
        else if (clrAcc)
            accReg <= 12'h000;
    end

    // --------------------------------------------------------------------
    // Peak, trough and switching cycle tracking
    // --------------------------------------------------------------------
    // Running extremes restart at each dither cycle end with dither on and at each normal-mode peak group read.
    // A sample or cycle end on the restart edge opens the new span, so none is lost.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !chanOn)
        begin
            peakRun_reg   <= afr_pkg::PEAK_RST;
            troughRun_reg <= afr_pkg::TROUGH_RST;
            cycRun_reg    <= afr_pkg::CYC_RST;
        end
        else if (clrPeak || (ditherOn && ditherEnd))
        begin
            peakRun_reg   <= sampleValid ? sampleCur : afr_pkg::PEAK_RST;
            troughRun_reg <= sampleValid ? sampleCur : afr_pkg::TROUGH_RST;
            cycRun_reg    <= cycleEnd ? 8'h01 : afr_pkg::CYC_RST;
        end
        else
        begin
            if (sampleValid && sampleCur > peakRun_reg)
                peakRun_reg <= sampleCur;
            if (sampleValid && sampleCur < troughRun_reg)
                troughRun_reg <= sampleCur;
            if (cycleEnd && cycRun_reg != 8'hFF)
                cycRun_reg <= cycRun_reg + 8'h01;
        end
    end

    // Results of the last complete dither cycle; a capture beats a read clear.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !chanOn)
        begin
            peakHold_reg   <= afr_pkg::PEAK_RST;
            troughHold_reg <= afr_pkg::TROUGH_RST;
            cycHold_reg    <= afr_pkg::CYC_RST;
        end
        else if (ditherOn && ditherEnd)
        begin
            peakHold_reg   <= peakRun_reg;
            troughHold_reg <= troughRun_reg;
            cycHold_reg    <= cycRun_reg;
        end
        else if (clrPeak)
        begin
            peakHold_reg   <= afr_pkg::PEAK_RST;
            troughHold_reg <= afr_pkg::TROUGH_RST;
            cycHold_reg    <= afr_pkg::CYC_RST;
        end
    end

    // With dither the held cycle is shown, otherwise peak and trough since the last peak group read and a zero cycle count.
    assign peakRep   = ditherOn ? peakHold_reg   : peakRun_reg;
    assign troughRep = ditherOn ? troughHold_reg : troughRun_reg;
    assign cycRep    = ditherOn ? cycHold_reg    : 8'h00;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    a_acc_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
        chanOn && cycleEnd ##1 chanOn |-> accReg == $past(accIn))
        else $error("accumulated current not captured at cycle end");

    a_peak_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
        clrPeak && !ditherOn && !sampleValid |=> peakRun_reg == 8'h00 && troughRun_reg == 8'hFF)
        else $error("peak or trough not restarted after read");

    a_tick_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
        tick |=> (!tick) [*8])
        else $error("period tick came too early");

endmodule // afr_chan_meas

`default_nettype wire

// file: afr_regs.sv
// Offset calibration trigger and measurement readback registers of a
// two-channel current driver, served one 32-bit frame at a time.
// Assumes the serial front end presents each whole frame with a one-cycle
// strobe and ships back the registered answer as the next frame's reply.
`timescale 1ns/1ps
`default_nettype none

module afr_regs
#(
    parameter int NUM_CH = 2
)
(
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   frameValid,
    input  wire logic [31:0]            frameData,
    output logic      [31:0]            readData,
    output logic                        readValid,
    input  wire logic                   calMode,
    input  wire logic [NUM_CH-1:0]      feedbackSelect,
    input  wire logic [NUM_CH-1:0]      chanOn,
    input  wire logic [NUM_CH-1:0]      ditherOn,
    input  wire logic [NUM_CH-1:0]      sampleValid,
    input  wire logic [NUM_CH-1:0][7:0] sampleCur,
    input  wire logic [NUM_CH-1:0][15:0] calCur,
    input  wire logic [NUM_CH-1:0]      cycleEnd,
    input  wire logic [NUM_CH-1:0][11:0] accIn,
    input  wire logic [NUM_CH-1:0]      ditherEnd,
    input  wire logic [NUM_CH-1:0]      azDone,
    input  wire logic [NUM_CH-1:0][12:0] azValue,
    output logic      [NUM_CH-1:0]      offsetCalTrigger
);

    // ----------------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------------
    if (NUM_CH != 2)
    begin : g_bad_ch
        $error("afr_regs serves exactly two channels");
    end

    logic                    isWrite;
    logic [3:0]              regCode;
    logic [1:0]              chanField;
    logic [NUM_CH-1:0]       chanHit;
    logic                    offsetHit;
    logic                    readbackHit;
    logic [NUM_CH-1:0]       clrAcc;
    logic [NUM_CH-1:0]       clrPeak;
    logic [NUM_CH-1:0][12:0] offsetVal;
    logic [NUM_CH-1:0][11:0] accVal;
    logic [NUM_CH-1:0][11:0] periodVal;
    logic [NUM_CH-1:0][7:0]  peakVal;
    logic [NUM_CH-1:0][7:0]  troughVal;
    logic [NUM_CH-1:0][7:0]  cycVal;
    logic [31:0]             reply_next;
    logic [23:0]             content;
    int                      sel;

    // ----------------------------------------------------------------------
    // Frame decode
    // ----------------------------------------------------------------------
    // Splits the frame into direction, register code and channel.
    assign isWrite     = frameData[afr_pkg::RW_BIT];
    assign regCode     = frameData[afr_pkg::CODE_HI:afr_pkg::CODE_LO];
    assign chanField   = frameData[afr_pkg::CHAN_HI:afr_pkg::CHAN_LO];
    assign chanHit[0]  = (chanField == afr_pkg::CHAN_ONE);
    assign chanHit[1]  = (chanField == afr_pkg::CHAN_TWO);
    assign offsetHit   = frameValid && (regCode == afr_pkg::CODE_OFFSET);
    assign readbackHit = frameValid && (regCode == afr_pkg::CODE_READBACK);

    // ----------------------------------------------------------------------
    // Per-channel measurement keepers
    // ----------------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        // A readback in normal mode clears the accumulated current or the peak group it just returned.
        assign clrAcc[c]  = readbackHit && chanHit[c] && !calMode && !feedbackSelect[c];
        assign clrPeak[c] = readbackHit && chanHit[c] && !calMode && feedbackSelect[c];

        afr_chan_meas u_meas
        (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .chanOn      (chanOn[c]),
            .ditherOn    (ditherOn[c]),
            .sampleValid (sampleValid[c]),
            .sampleCur   (sampleCur[c]),
            .cycleEnd    (cycleEnd[c]),
            .accIn       (accIn[c]),
            .ditherEnd   (ditherEnd[c]),
            .azDone      (azDone[c]),
            .azValue     (azValue[c]),
            .clrAcc      (clrAcc[c]),
            .clrPeak     (clrPeak[c]),
            .offsetReg   (offsetVal[c]),
            .accReg      (accVal[c]),
            .periodReg   (periodVal[c]),
            .peakRep     (peakVal[c]),
            .troughRep   (troughVal[c]),
            .cycRep      (cycVal[c])
        );
    end

    // ----------------------------------------------------------------------
    // Calibration trigger
    // ----------------------------------------------------------------------
    // One-cycle start pulse to the addressed channel's calibration sequencer.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            offsetCalTrigger <= '0;
        else if (offsetHit && isWrite && frameData[afr_pkg::TRIGGER_BIT])
            offsetCalTrigger <= chanHit;
        else
            offsetCalTrigger <= '0;
    end

    // ----------------------------------------------------------------------
    // Reply assembly
    // ----------------------------------------------------------------------
    // Picks the addressed channel's copy and lays out the selected view.
    always_comb
    begin
        sel     = chanHit[1] ? 1 : 0;
        content = 24'h00_0000;
        if (regCode == afr_pkg::CODE_OFFSET)
            content[afr_pkg::OFFSET_W-1:0] = offsetVal[sel];
        else if (calMode)
            content[afr_pkg::CAL_LO +: afr_pkg::CAL_W] = calCur[sel];
        else if (!chanOn[sel])
            content = 24'h00_0000;
        else if (!feedbackSelect[sel])
        begin
            content[afr_pkg::ACC_LO +: afr_pkg::ACC_W]       = accVal[sel];
            content[afr_pkg::PERIOD_LO +: afr_pkg::PERIOD_W] = periodVal[sel];
        end
        else
        begin
            content[afr_pkg::PEAK_LO +: afr_pkg::CUR_W]   = peakVal[sel];
            content[afr_pkg::TROUGH_LO +: afr_pkg::CUR_W] = troughVal[sel];
            content[afr_pkg::CYC_LO +: afr_pkg::CUR_W]    = cycVal[sel];
        end
        if (chanHit == '0)
            content = 24'h00_0000;
        reply_next = {1'b0, regCode, 1'b0, chanField, content};
    end

    // Registers the reply; readback writes store nothing and act as reads.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            readData  <= 32'h0000_0000;
            readValid <= 1'b0;
        end
        else
        begin
            readValid <= offsetHit || readbackHit;
            if (offsetHit || readbackHit)
                readData <= reply_next;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_trigger_one;
        offsetHit && isWrite && frameData[afr_pkg::TRIGGER_BIT] && chanHit[0];
    endsequence

    sequence s_readback_idle_one;
        readbackHit && chanHit[0] && !calMode && !chanOn[0];
    endsequence

    a_rw_reads_zero: assert property (readValid |-> !readData[31])
        else $error("reply shows direction bit set");

    a_chan_echo: assert property (frameValid && (offsetHit || readbackHit)
        |=> readData[25:24] == $past(chanField))
        else $error("reply channel field differs from request");

    a_trigger_pulse: assert property (s_trigger_one
        ##1 !(offsetHit && isWrite && frameData[afr_pkg::TRIGGER_BIT] && chanHit[0])
        |-> offsetCalTrigger == 2'b01 ##1 !offsetCalTrigger[0])
        else $error("calibration start not a single pulse on channel one");

    a_trigger_zero: assert property (offsetHit && !frameData[23] |=> offsetCalTrigger == 2'b00)
        else $error("calibration started without trigger bit");

    a_offset_reply: assert property (offsetHit && !isWrite && chanHit[1]
        |=> readData[12:0] == $past(offsetVal[1]) && readData[23:13] == 11'h000)
        else $error("offset reply wrong for channel two");

    a_idle_zero: assert property (s_readback_idle_one |=> readData[23:0] == 24'h00_0000)
        else $error("idle channel reply not zero");

    a_write_as_read: assert property (readbackHit && isWrite |=> readValid)
        else $error("readback write not answered as read");

    a_cal_view: assert property (readbackHit && calMode && chanHit[0]
        |=> readData[23:8] == $past(calCur[0]))
        else $error("calibration current reply wrong");

    a_clear_on_read: assert property (readbackHit && chanHit[1] && !calMode && feedbackSelect[1]
        && chanOn[1] && !sampleValid[1] && !cycleEnd[1] && !ditherEnd[1]
        |=> peakVal[1] == 8'h00 && troughVal[1] == 8'hFF && cycVal[1] == 8'h00)
        else $error("peak group not cleared on read");

endmodule // afr_regs

`default_nettype wire

// file: afr_host_model.sv
// Host side model: presents whole register frames to the block.
// Assumes calls are made just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none

module afr_host_model
(
    input  wire logic        core_clk,
    output logic             frameValid,
    output logic [31:0]      frameData
);
    // ----------------------------------------------------------------------
    // Frame driver
    // ----------------------------------------------------------------------
    logic held = 1'b0;

    // Lines start idle with the strobe low.
    initial
    begin
        frameValid = 1'b0;
        frameData  = 32'h0000_0000;
    end

    // Sends one frame for one cycle; hold keeps the strobe up for a frame right behind it.
    task automatic send(input logic wr, input logic [3:0] code, input logic [1:0] ch,
                        input logic start, input logic hold);
        if (!held)
        begin
            @(posedge core_clk);
            #1;
        end
        frameValid = 1'b1;
        frameData  = {wr, code, 1'b0, ch, start, 23'h00_0000};
        @(posedge core_clk);
        #1;
        held = hold;
        if (!hold)
        begin
            frameValid = 1'b0;
            frameData  = ~frameData; // Stale word is inverted so it never passes for a frame.
        end
    endtask
endmodule // afr_host_model

`default_nettype wire

// file: tb_autozero_feedback_regs.sv
// Self-checking bench for the offset calibration and readback registers.
// Assumes afr_regs with two channels, fed frames by afr_host_model.
`timescale 1ns/1ps
`default_nettype none

module tb_autozero_feedback_regs;
    localparam logic [3:0] OFS = afr_pkg::CODE_OFFSET;
    localparam logic [3:0] RBK = afr_pkg::CODE_READBACK;
    localparam logic [1:0] C1  = afr_pkg::CHAN_ONE;
    localparam logic [1:0] C2  = afr_pkg::CHAN_TWO;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             frameValid, readValid;
    logic      [31:0] frameData, readData;
    logic             calMode = 1'b0;
    logic      [1:0]  feedbackSelect = 2'h0, chanOn = 2'h0, ditherOn = 2'h0, sampleValid = 2'h0;
    logic      [1:0]  cycleEnd = 2'h0, ditherEnd = 2'h0, azDone = 2'h0, offsetCalTrigger;
    logic [1:0][7:0]  sampleCur = 16'h0000;
    logic [1:0][15:0] calCur = 32'h0000_0000;
    logic [1:0][11:0] accIn = 24'h00_0000;
    logic [1:0][12:0] azValue = 26'h000_0000;
    logic      [31:0] replyQ[$];
    logic      [1:0]  trigQ[$];
    logic      [12:0] az;
    logic      [11:0] acc;
    logic      [7:0]  pk, tr;
    integer           seed = 32'h667d;
    int               miscompares = 0, checks = 0, cycles = 0;

    // 40 MHz clock.
    always #12.5 core_clk = ~core_clk;

    afr_host_model HOST (.core_clk(core_clk), .frameValid(frameValid), .frameData(frameData));

    afr_regs #(.NUM_CH(2)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .frameValid(frameValid), .frameData(frameData),
        .readData(readData), .readValid(readValid), .calMode(calMode),
        .feedbackSelect(feedbackSelect), .chanOn(chanOn), .ditherOn(ditherOn),
        .sampleValid(sampleValid), .sampleCur(sampleCur), .calCur(calCur), .cycleEnd(cycleEnd),
        .accIn(accIn), .ditherEnd(ditherEnd), .azDone(azDone), .azValue(azValue),
        .offsetCalTrigger(offsetCalTrigger));

    // ----------------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------------
    task automatic cmpReply(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t reply got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpTrig(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t trigger got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Notes left unanswered count as mismatches.
    task automatic results();
        miscompares += replyQ.size() + trigQ.size();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Takes the oldest note off each queue as replies and triggers appear; also cuts hangs.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            miscompares++;
            results();
        end
        else
        begin
            if (readValid === 1'b1)
                cmpReply(readData, replyQ.size() ? replyQ.pop_front() : 32'hxxxx_xxxx);
            if (offsetCalTrigger !== 2'h0)
                cmpTrig(offsetCalTrigger, trigQ.size() ? trigQ.pop_front() : 2'h0);
        end
    end

    // ----------------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------------
    task automatic waitCyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse(ref logic [1:0] sig, input int c);
        sig[c] = 1'b1;
        waitCyc(1);
        sig[c] = 1'b0;
    endtask

    // Notes the expected reply and trigger, then has the host send the frame.
    task automatic xfer(input logic wr, input logic [3:0] code, input logic [1:0] ch, input logic start,
                        input logic [23:0] content, input logic hold);
        if (code == OFS || code == RBK)
            replyQ.push_back({1'b0, code, 1'b0, ch, content});
        if (wr && start && code == OFS && (ch == C1 || ch == C2))
            trigQ.push_back(ch);
        HOST.send(wr, code, ch, start, hold);
    endtask

    // Feeds n random samples on channel two, each followed by a cycle end.
    task automatic track(input int n);
        pk = 8'h00;
        tr = 8'hFF;
        repeat (n)
        begin
            sampleCur[1] = 8'($random(seed));
            pk = (sampleCur[1] > pk) ? sampleCur[1] : pk;
            tr = (sampleCur[1] < tr) ? sampleCur[1] : tr;
            pulse(sampleValid, 1);
            pulse(cycleEnd, 1);
        end
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial
    begin
        waitCyc(20);
        rst_n = 1'b1;
        xfer(1'b0, OFS, C1, 1'b0, 24'h00_0000, 1'b0);
        xfer(1'b0, RBK, C2, 1'b0, 24'h00_0000, 1'b0);
        $display("test reset done");
        // Channels stay off while triggers are asked for; four frames back to back.
        for (int c = 0; c < 4; c++)
            xfer(1'b1, OFS, 2'(c), 1'b1, 24'h00_0000, c < 3);
        xfer(1'b1, OFS, C1, 1'b0, 24'h00_0000, 1'b0);
        $display("test trigger done");
        az = 13'($random(seed));
        azValue[0] = az;
        pulse(azDone, 0);
        azValue[0] = ~az;
        xfer(1'b0, OFS, C1, 1'b0, {11'h000, az}, 1'b0);
        xfer(1'b0, OFS, C2, 1'b0, 24'h00_0000, 1'b0);
        $display("test offset done");
        chanOn = 2'h1;
        accIn[0] = 12'($random(seed));
        pulse(cycleEnd, 0);
        waitCyc(159);
        acc = 12'($random(seed));
        accIn[0] = acc;
        pulse(cycleEnd, 0);
        accIn[0] = ~acc;
        xfer(1'b0, RBK, C1, 1'b0, {acc, 12'(160 / afr_pkg::PERIOD_LSB_CLKS)}, 1'b0);
        xfer(1'b0, RBK, C1, 1'b0, {12'h000, 12'(160 / afr_pkg::PERIOD_LSB_CLKS)}, 1'b0);
        $display("test period done");
        chanOn = 2'h3;
        feedbackSelect = 2'h2;
        track(3);
        xfer(1'b0, RBK, C2, 1'b0, {pk, tr, 8'h00}, 1'b0);
        xfer(1'b0, RBK, C2, 1'b0, {8'h00, 8'hFF, 8'h00}, 1'b0);
        ditherOn = 2'h2;
        pulse(ditherEnd, 1);
        track(4);
        pulse(ditherEnd, 1);
        xfer(1'b0, RBK, C2, 1'b0, {pk, tr, 8'h04}, 1'b0);
        chanOn = 2'h0;
        for (int c = 1; c < 3; c++)
            xfer(1'b0, RBK, 2'(c), 1'b0, 24'h00_0000, 1'b0);
        $display("test peak done");
        calMode = 1'b1;
        calCur = 32'($random(seed));
        xfer(1'b0, RBK, C1, 1'b0, {calCur[0], 8'h00}, 1'b0);
        xfer(1'b1, RBK, C2, 1'b1, {calCur[1], 8'h00}, 1'b0);
        xfer(1'b0, 4'h2, C1, 1'b0, 24'h00_0000, 1'b0);
        waitCyc(4);
        $display("test calibration done");
        results();
    end
endmodule // tb_autozero_feedback_regs

`default_nettype wire
